// ==== rtl/pcr_pkg.sv ====
`default_nettype none

package pcr_pkg;

    // ==========================================================
    // register offsets (byte addresses in configuration space)
    localparam logic [7:0] PCR_OFS_CLASS_REV = 8'h08;
    localparam logic [7:0] PCR_OFS_LATENCY = 8'h0C;
    localparam logic [7:0] PCR_OFS_IO_BASE = 8'h10;
    localparam logic [7:0] PCR_OFS_MEM_BASE = 8'h14;
    localparam logic [7:0] PCR_OFS_SUBSYS = 8'h2C;
    localparam logic [7:0] PCR_OFS_ROM_BASE = 8'h30;

    // ==========================================================
    // fixed codes
    localparam logic [7:0] PCR_BASE_CLASS_CODE = 8'h02;
    localparam logic [7:0] PCR_SUB_CLASS_CODE = 8'h00;
    localparam logic [7:0] PCR_PROG_IF_CODE = 8'h00;

    // ==========================================================
    // reset values
    localparam logic [31:0] PCR_RST_LATENCY = 32'h00000000;
    localparam logic [31:0] PCR_RST_IO_BASE = 32'h00000001;
    localparam logic [31:0] PCR_RST_MEM_BASE = 32'h00000000;
    localparam logic [31:0] PCR_RST_ROM_BASE = 32'h00000000;

    // ==========================================================
    // writable bit masks; all other bits are fixed
    localparam logic [31:0] PCR_WMASK_LATENCY = 32'h0000FF00;
    localparam logic [31:0] PCR_WMASK_IO_BASE = 32'hFFFFFF00;
    localparam logic [31:0] PCR_WMASK_MEM_BASE = 32'hFFFFF000;
    localparam logic [31:0] PCR_WMASK_ROM_BASE = 32'hFFFE0001;

    // ==========================================================
    // field positions
    localparam int PCR_LAT_LSB = 8;
    localparam int PCR_IO_BASE_LSB = 8;
    localparam int PCR_MEM_BASE_LSB = 12;
    localparam int PCR_ROM_BASE_LSB = 17;
    localparam int PCR_ROM_EN_BIT = 0;

    // ==========================================================
    // configuration access carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcr_cfg_req_t;

endpackage

`default_nettype wire

// ==== rtl/pcr_config_header_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcr_config_header_regs
    import pcr_pkg::*;
#(
    // arbitrary neutral values
    parameter logic [7:0] SILICON_REVISION_CODE = 8'h5A,
    parameter logic [15:0] SUBSYS_PRODUCT_DEFAULT = 16'hA5C3,
    parameter logic [15:0] SUBSYS_MAKER_DEFAULT = 16'h3C5A
)
(
    // clock and resets
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic SOFT_RST,
    // configuration access
    input wire pcr_cfg_req_t CFG_REQ,
    output logic CFG_RVALID,
    output logic [31:0] CFG_RDATA,
    // command register enables and auto-load values
    input wire logic IO_SPACE_EN,
    input wire logic MEM_SPACE_EN,
    input wire logic AUTOLOAD_EN,
    input wire logic [15:0] EE_SUBSYS_PRODUCT,
    input wire logic [15:0] EE_SUBSYS_MAKER,
    // target address decode
    input wire logic [31:0] TARGET_ADDR,
    output logic IO_HIT,
    output logic MEM_HIT,
    output logic ROM_HIT,
    // master tenure
    input wire logic MASTER_FRAME,
    output logic HOLD_EXPIRED,
    output logic [7:0] BUS_HOLD_LIMIT
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_write(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old & ~lane) | (wdata & lane);
    endfunction

    // ==========================================================
    // registers
    logic [31:0] latency_misc_word_ff;
    logic [31:0] io_window_base_reg_ff;
    logic [31:0] mem_window_base_reg_ff;
    logic [31:0] rom_window_base_reg_ff;
    logic [31:0] nxt_latency_misc_word;
    logic [31:0] nxt_io_window_base_reg;
    logic [31:0] nxt_mem_window_base_reg;
    logic [31:0] nxt_rom_window_base_reg;
    logic [31:0] rdata_ff;
    logic rvalid_ff;
    logic [7:0] tenure_ff;
    logic [7:0] nxt_tenure;

    // ==========================================================
    // write decode
    wire wr_lat = CFG_REQ.wr && (CFG_REQ.addr == PCR_OFS_LATENCY);
    wire wr_io = CFG_REQ.wr && (CFG_REQ.addr == PCR_OFS_IO_BASE);
    wire wr_mem = CFG_REQ.wr && (CFG_REQ.addr == PCR_OFS_MEM_BASE);
    wire wr_rom = CFG_REQ.wr && (CFG_REQ.addr == PCR_OFS_ROM_BASE);

    // masks keep fixed fields fixed
    assign nxt_latency_misc_word = wr_lat ? merge_write(latency_misc_word_ff,
        CFG_REQ.wdata, CFG_REQ.be, PCR_WMASK_LATENCY) : latency_misc_word_ff;
    assign nxt_io_window_base_reg = wr_io ? merge_write(io_window_base_reg_ff,
        CFG_REQ.wdata, CFG_REQ.be, PCR_WMASK_IO_BASE) : io_window_base_reg_ff;
    assign nxt_mem_window_base_reg = wr_mem ? merge_write(mem_window_base_reg_ff,
        CFG_REQ.wdata, CFG_REQ.be, PCR_WMASK_MEM_BASE) : mem_window_base_reg_ff;
    assign nxt_rom_window_base_reg = wr_rom ? merge_write(rom_window_base_reg_ff,
        CFG_REQ.wdata, CFG_REQ.be, PCR_WMASK_ROM_BASE) : rom_window_base_reg_ff;

    // soft reset deliberately absent here
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            latency_misc_word_ff <= PCR_RST_LATENCY;
            io_window_base_reg_ff <= PCR_RST_IO_BASE;
            mem_window_base_reg_ff <= PCR_RST_MEM_BASE;
            rom_window_base_reg_ff <= PCR_RST_ROM_BASE;
        end
        else
        begin
            latency_misc_word_ff <= nxt_latency_misc_word;
            io_window_base_reg_ff <= nxt_io_window_base_reg;
            mem_window_base_reg_ff <= nxt_mem_window_base_reg;
            rom_window_base_reg_ff <= nxt_rom_window_base_reg;
        end
    end

    // ==========================================================
    // read path
    wire [31:0] class_revision_word = {PCR_BASE_CLASS_CODE, PCR_SUB_CLASS_CODE,
        PCR_PROG_IF_CODE, SILICON_REVISION_CODE};
    wire [15:0] subsys_product_code = AUTOLOAD_EN ? EE_SUBSYS_PRODUCT
        : SUBSYS_PRODUCT_DEFAULT;
    wire [15:0] subsys_maker_code = AUTOLOAD_EN ? EE_SUBSYS_MAKER
        : SUBSYS_MAKER_DEFAULT;
    wire [31:0] subsystem_ident_word = {subsys_product_code, subsys_maker_code};
    wire [31:0] rd_mux =
        (CFG_REQ.addr == PCR_OFS_CLASS_REV) ? class_revision_word :
        (CFG_REQ.addr == PCR_OFS_LATENCY) ? latency_misc_word_ff :
        (CFG_REQ.addr == PCR_OFS_IO_BASE) ? io_window_base_reg_ff :
        (CFG_REQ.addr == PCR_OFS_MEM_BASE) ? mem_window_base_reg_ff :
        (CFG_REQ.addr == PCR_OFS_SUBSYS) ? subsystem_ident_word :
        (CFG_REQ.addr == PCR_OFS_ROM_BASE) ? rom_window_base_reg_ff :
        32'h00000000;

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_ff <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= CFG_REQ.rd;
            if (CFG_REQ.rd)
            begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign CFG_RVALID = rvalid_ff;
    assign CFG_RDATA = rdata_ff;

    // ==========================================================
    // window decode
    wire io_match = TARGET_ADDR[31:PCR_IO_BASE_LSB]
        == io_window_base_reg_ff[31:PCR_IO_BASE_LSB];
    wire mem_match = TARGET_ADDR[31:PCR_MEM_BASE_LSB]
        == mem_window_base_reg_ff[31:PCR_MEM_BASE_LSB];
    wire rom_match = TARGET_ADDR[31:PCR_ROM_BASE_LSB]
        == rom_window_base_reg_ff[31:PCR_ROM_BASE_LSB];
    wire rom_decode_enable = rom_window_base_reg_ff[PCR_ROM_EN_BIT];

    assign IO_HIT = IO_SPACE_EN && io_match;
    assign MEM_HIT = MEM_SPACE_EN && mem_match;
    assign ROM_HIT = MEM_SPACE_EN && rom_decode_enable && rom_match;

    // ==========================================================
    // master tenure limit
    wire [7:0] bus_hold_limit = latency_misc_word_ff[PCR_LAT_LSB +: 8];
    wire tenure_full = tenure_ff >= bus_hold_limit;

    assign nxt_tenure = (!MASTER_FRAME || SOFT_RST) ? 8'h00
        : (tenure_full ? tenure_ff : tenure_ff + 8'h01);

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tenure_ff <= 8'h00;
        end
        else
        begin
            tenure_ff <= nxt_tenure;
        end
    end

    assign HOLD_EXPIRED = MASTER_FRAME && tenure_full;
    assign BUS_HOLD_LIMIT = bus_hold_limit;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    chk_class_read: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_CLASS_REV
        |=> CFG_RVALID && CFG_RDATA == {8'h02, 8'h00, 8'h00, SILICON_REVISION_CODE})
        else $error("class word read wrong");

    chk_selftest_zero: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_LATENCY |=> CFG_RDATA[31:24] == 8'h00)
        else $error("self-test byte not zero");

    chk_line_size_fixed: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_LATENCY |=> CFG_RDATA[7:0] == 8'h00)
        else $error("line size byte not fixed");

    chk_hold_limit_write: assert property (
        wr_lat && CFG_REQ.be[1] |=> BUS_HOLD_LIMIT == $past(CFG_REQ.wdata[15:8]))
        else $error("hold limit not written");

    chk_hold_expiry: assert property (
        MASTER_FRAME && !SOFT_RST && BUS_HOLD_LIMIT == 8'h02 && tenure_ff == 8'h00
        ##1 MASTER_FRAME && !SOFT_RST && $stable(BUS_HOLD_LIMIT)
        |=> !MASTER_FRAME || HOLD_EXPIRED)
        else $error("tenure not ended at limit");

    chk_io_base_write: assert property (
        wr_io && CFG_REQ.be == 4'hF |=> IO_HIT == (IO_SPACE_EN
        && TARGET_ADDR[31:8] == $past(CFG_REQ.wdata[31:8])))
        else $error("io base not written");

    chk_io_low_bits: assert property (
        io_window_base_reg_ff[7:0] == 8'h01)
        else $error("io base low bits wrong");

    chk_mem_low_bits: assert property (
        mem_window_base_reg_ff[11:0] == 12'h000)
        else $error("memory base low bits wrong");

    chk_mem_base_write: assert property (
        wr_mem && CFG_REQ.be == 4'hF |=> mem_window_base_reg_ff[31:12]
        == $past(CFG_REQ.wdata[31:12]))
        else $error("memory base not written");

    chk_rom_reserved: assert property (
        wr_rom && CFG_REQ.be == 4'hF |=> rom_window_base_reg_ff
        == ($past(CFG_REQ.wdata) & 32'hFFFE0001))
        else $error("rom base write wrong");

    chk_rom_claim: assert property (
        ROM_HIT |-> MEM_SPACE_EN && rom_window_base_reg_ff[0])
        else $error("rom claimed while disabled");

    chk_mem_claim: assert property (
        !MEM_SPACE_EN |-> !MEM_HIT && !ROM_HIT)
        else $error("memory claimed while disabled");

    chk_subsys_read: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_SUBSYS && !AUTOLOAD_EN
        |=> CFG_RDATA == {SUBSYS_PRODUCT_DEFAULT, SUBSYS_MAKER_DEFAULT})
        else $error("subsystem word wrong");

    chk_soft_keep: assert property (
        SOFT_RST && !CFG_REQ.wr |=> $stable(io_window_base_reg_ff)
        && $stable(mem_window_base_reg_ff) && $stable(rom_window_base_reg_ff)
        && $stable(latency_misc_word_ff))
        else $error("soft reset changed a register");

    chk_ro_discard: assert property (
        wr_lat |=> latency_misc_word_ff[31:16] == 16'h0000)
        else $error("read-only bits changed");

    // ==========================================================
    // read-back, window and tenure checks
    chk_io_read_low: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_IO_BASE
        |=> CFG_RVALID && CFG_RDATA[7:0] == 8'h01)
        else $error("io base low bits read wrong");

    chk_mem_read_low: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_MEM_BASE
        |=> CFG_RVALID && CFG_RDATA[11:0] == 12'h000)
        else $error("memory base low bits read wrong");

    chk_rom_read_resv: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_ROM_BASE
        |=> CFG_RVALID && CFG_RDATA[16:1] == 16'h0000)
        else $error("rom reserved bits read wrong");

    chk_subsys_autoload: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_SUBSYS && AUTOLOAD_EN
        |=> CFG_RDATA[31:16] == $past(EE_SUBSYS_PRODUCT)
        && CFG_RDATA[15:0] == $past(EE_SUBSYS_MAKER))
        else $error("loaded subsystem word wrong");

    chk_hold_readback: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_LATENCY
        |=> CFG_RDATA[15:8] == $past(BUS_HOLD_LIMIT))
        else $error("hold limit read back wrong");

    chk_io_read_back: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_IO_BASE
        |=> CFG_RDATA == $past(io_window_base_reg_ff))
        else $error("io base read back wrong");

    chk_rom_read_back: assert property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_ROM_BASE
        |=> CFG_RDATA == $past(rom_window_base_reg_ff))
        else $error("rom base read back wrong");

    chk_hold_idle: assert property (
        !MASTER_FRAME |-> !HOLD_EXPIRED)
        else $error("tenure end flagged outside frame");

    chk_tenure_soft_clear: assert property (
        SOFT_RST |=> tenure_ff == 8'h00)
        else $error("soft reset left tenure count");

    chk_rom_enable_write: assert property (
        wr_rom && CFG_REQ.be[0] |=> rom_window_base_reg_ff[PCR_ROM_EN_BIT]
        == $past(CFG_REQ.wdata[0]))
        else $error("rom decode enable not written");

    chk_io_claim: assert property (
        !IO_SPACE_EN |-> !IO_HIT)
        else $error("io claimed while disabled");

    chk_hold_saturate: assert property (
        MASTER_FRAME && !SOFT_RST && !wr_lat && HOLD_EXPIRED
        |=> !MASTER_FRAME || HOLD_EXPIRED)
        else $error("tenure end dropped during frame");

    chk_io_base_keep: assert property (
        !wr_io |=> $stable(io_window_base_reg_ff))
        else $error("io base changed without write");

    chk_mem_base_keep: assert property (
        !wr_mem |=> $stable(mem_window_base_reg_ff))
        else $error("memory base changed without write");

    chk_rom_base_keep: assert property (
        !wr_rom |=> $stable(rom_window_base_reg_ff))
        else $error("rom base changed without write");

    chk_latency_keep: assert property (
        !wr_lat |=> $stable(latency_misc_word_ff))
        else $error("latency word changed without write");

    cov_io_write: cover property (wr_io ##1 IO_HIT);
    cov_rom_hit: cover property (wr_rom ##[1:8] ROM_HIT);
    cov_hold_expired: cover property (MASTER_FRAME ##1 HOLD_EXPIRED);
    cov_soft_in_frame: cover property (MASTER_FRAME && SOFT_RST);
    cov_autoload_read: cover property (
        CFG_REQ.rd && CFG_REQ.addr == PCR_OFS_SUBSYS && AUTOLOAD_EN);

endmodule // pcr_config_header_regs

`default_nettype wire

// ==== testbench/pcr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model
    import pcr_pkg::*;
(
    // clock
    input wire logic clk,
    // configuration request toward the device
    output var pcr_cfg_req_t cfg_req
);
    // ==========================================================
    // configuration cycles
    initial cfg_req = '0;

    // request stays up until the next call replaces it
    task automatic cfg_access(input logic w, input logic r, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d);
        cfg_req = {w, r, a, be, d};
        @(posedge clk);
        #1;
    endtask

    // released wr and rd drop to zero; the other lines show the inverse of their last value
    task automatic cfg_idle(input int n);
        cfg_req = {2'b00, ~cfg_req.addr, ~cfg_req.be, ~cfg_req.wdata};
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask
endmodule // pcr_host_model

`default_nettype wire

// ==== testbench/tb_pci_config_header_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_pci_config_header_regs
    import pcr_pkg::*;
;
    // arbitrary values
    localparam logic [7:0] REV = 8'h3E;
    localparam logic [15:0] PDEF = 16'h7B21;
    localparam logic [15:0] MDEF = 16'h4D96;
    logic clock, arst_n, soft_rst, io_en, mem_en, al_en, frame;
    logic rvalid, io_hit, mem_hit, rom_hit, expired;
    logic [15:0] ee_p, ee_m;
    logic [31:0] taddr, rdata, sh_lat, sh_io, sh_mem, sh_rom, seed, t;
    logic [7:0] lim;
    pcr_cfg_req_t req;
    int bad_count, total_checks;
    logic [7:0] offs [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C, 8'h30, 8'h20, 8'h3C};

    pcr_config_header_regs #(.SILICON_REVISION_CODE(REV), .SUBSYS_PRODUCT_DEFAULT(PDEF),
        .SUBSYS_MAKER_DEFAULT(MDEF)) uut (.CLOCK(clock), .ARST_N(arst_n),
        .SOFT_RST(soft_rst), .CFG_REQ(req), .CFG_RVALID(rvalid), .CFG_RDATA(rdata),
        .IO_SPACE_EN(io_en), .MEM_SPACE_EN(mem_en), .AUTOLOAD_EN(al_en),
        .EE_SUBSYS_PRODUCT(ee_p), .EE_SUBSYS_MAKER(ee_m), .TARGET_ADDR(taddr),
        .IO_HIT(io_hit), .MEM_HIT(mem_hit), .ROM_HIT(rom_hit), .MASTER_FRAME(frame),
        .HOLD_EXPIRED(expired), .BUS_HOLD_LIMIT(lim));
    pcr_host_model host (.clk(clock), .cfg_req(req));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ==========================================================
    // expectations
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] be,
        input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
        return (o & ~bm) | (d & bm);
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            PCR_OFS_CLASS_REV: return {8'h02, 8'h00, 8'h00, REV};
            PCR_OFS_LATENCY: return sh_lat;
            PCR_OFS_IO_BASE: return sh_io;
            PCR_OFS_MEM_BASE: return sh_mem;
            PCR_OFS_SUBSYS: return al_en ? {ee_p, ee_m} : {PDEF, MDEF};
            PCR_OFS_ROM_BASE: return sh_rom;
            default: return 32'h00000000;
        endcase
    endfunction

    // ==========================================================
    // checking and access tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic r, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d);
        logic [31:0] e;
        e = exp_rd(a);
        host.cfg_access(w, r, a, be, d);
        check(rvalid, r);
        if (r)
            check(rdata, e);
        if (w)
            case (a)
                PCR_OFS_LATENCY: sh_lat = merge(sh_lat, d, be, 32'h0000FF00);
                PCR_OFS_IO_BASE: sh_io = merge(sh_io, d, be, 32'hFFFFFF00);
                PCR_OFS_MEM_BASE: sh_mem = merge(sh_mem, d, be, 32'hFFFFF000);
                PCR_OFS_ROM_BASE: sh_rom = merge(sh_rom, d, be, 32'hFFFE0001);
                default: ;
            endcase
    endtask

    task automatic read_all();
        foreach (offs[i])
            acc(1'b0, 1'b1, offs[i], 4'h0, 32'h00000000);
    endtask

    task automatic defaults();
        sh_lat = 32'h00000000;
        sh_io = 32'h00000001;
        sh_mem = 32'h00000000;
        sh_rom = 32'h00000000;
    endtask

    task automatic tenure(input logic [7:0] l);
        acc(1'b1, 1'b0, PCR_OFS_LATENCY, 4'hF, {16'hFFFF, l, 8'hFF});
        check(lim, l);
        host.cfg_idle(0);
        frame = 1'b1;
        #1;
        check(expired, l == 8'h00);
        for (int k = 1; k <= l + 1; k++)
        begin
            @(posedge clock);
            #1;
            check(expired, k >= l);
        end
        soft_rst = 1'b1;
        @(posedge clock);
        #1;
        soft_rst = 1'b0;
        check(expired, l == 8'h00);
        frame = 1'b0;
        read_all();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        seed = 32'h000021C2;
        bad_count = 0;
        total_checks = 0;
        {arst_n, soft_rst, io_en, mem_en, al_en, frame} = 6'h00;
        {ee_p, ee_m, taddr} = 64'h0;
        defaults();
        repeat (6) @(posedge clock);
        #1;
        arst_n = 1'b1;
        read_all();
        foreach (offs[i])
            acc(1'b1, 1'b0, offs[i], 4'hF, 32'hFFFFFFFF);
        read_all();
        for (int i = 0; i < 150; i++)
        begin
            t = rnd();
            {ee_p, ee_m} = rnd();
            io_en = t[28];
            mem_en = t[29];
            al_en = t[4];
            case (t[1:0])
                2'h0: taddr = {sh_io[31:8], t[15:8]};
                2'h1: taddr = {sh_mem[31:12], t[19:8]};
                2'h2: taddr = {sh_rom[31:17], t[24:8]};
                default: taddr = rnd();
            endcase
            if (t[5])
                host.cfg_idle(1);
            acc(t[6], t[7], offs[t[10:8]], t[15:12], rnd());
            check(io_hit, io_en && taddr[31:8] == sh_io[31:8]);
            check(mem_hit, mem_en && taddr[31:12] == sh_mem[31:12]);
            check(rom_hit, mem_en && sh_rom[0] && taddr[31:17] == sh_rom[31:17]);
        end
        tenure(8'h00);
        tenure(8'h01);
        tenure(8'h02);
        tenure(8'h06);
        host.cfg_idle(0);
        arst_n = 1'b0;
        @(posedge clock);
        #1;
        arst_n = 1'b1;
        defaults();
        read_all();
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        end_of_test();
    end
endmodule // tb_pci_config_header_regs

`default_nettype wire
